// [itar_defs.svh]
// Offsets, reset values and limits of the input terminal and analog block
`ifndef ITAR_DEFS_SVH
`define ITAR_DEFS_SVH
`define ITAR_ADDR_FAST_CFG 8'h00
`define ITAR_ADDR_MASK_A   8'h04
`define ITAR_ADDR_MASK_B   8'h08
`define ITAR_ADDR_OFFSET   8'h0c
`define ITAR_ADDR_FILTER   8'h10
`define ITAR_ADDR_DEAD     8'h14
`define ITAR_ADDR_DRIFT    8'h18
`define ITAR_ADDR_ADJUST   8'h1c
`define ITAR_ADDR_SPD10    8'h20
`define ITAR_ADDR_TRQ10    8'h24
`define ITAR_ADDR_MODE     8'h28
`define ITAR_ADDR_STATUS   8'h2c
`define ITAR_ADDR_SAMPLE   8'h30
`define ITAR_ADDR_SPD_REF  8'h34
`define ITAR_ADDR_TRQ_REF  8'h38
`define ITAR_FUNC_NONE     6'h00
`define ITAR_FUNC_FLY      6'h20
`define ITAR_LOGIC_LOW     3'h0
`define ITAR_LOGIC_HIGH    3'h1
`define ITAR_LOGIC_RISE    3'h2
`define ITAR_LOGIC_FALL    3'h3
`define ITAR_LOGIC_BOTH    3'h4
`define ITAR_FILTER_RST    16'h00c8
`define ITAR_DEAD_RST      16'h0064
`define ITAR_SPD10_RST     16'h0bb8
`define ITAR_TRQ10_RST     16'h0064
`define ITAR_TRQ10_MIN     16'h0064
`define ITAR_TRQ10_MAX     16'h0320
`define ITAR_ADJ_START     32'h00000001
`define ITAR_DRIFT_LIMIT   21'h01388
`define ITAR_OV_LIMIT      21'h1c138
`define ITAR_TEN_VOLTS     38'h186a0
`define ITAR_ST_DRIFT      1
`define ITAR_ST_OV         2
`endif

// [itar_pkg.sv]
// Types of the input terminal and analog block
`default_nettype none
package itar_pkg;
  typedef enum logic [1:0] {
    ITAR_ADJ_IDLE    = 2'b01,
    ITAR_ADJ_MEASURE = 2'b10
  } itar_adj_state_type;

  typedef enum logic [1:0] {
    ITAR_MODE_POSITION = 2'h0,
    ITAR_MODE_SPEED    = 2'h1,
    ITAR_MODE_TORQUE   = 2'h2
  } itar_ctrl_mode_type;

  typedef struct packed {
    logic [1:0]         tlim_src;
    logic [1:0]         slim_src;
    logic [1:0]         trq_src;
    logic [1:0]         spd_src;
    logic [1:0]         ff_src;
    itar_ctrl_mode_type mode;
  } itar_mode_cfg_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } itar_apb_req_type;

  typedef struct packed {
    logic misalloc;
    logic drift;
    logic overvolt;
  } itar_fault_type;

  typedef struct packed {
    logic pulse_input_block;
    logic internal_speed_limit_source;
    logic clear_position_deviation;
    logic emergency_halt;
    logic fly_change_inhibit;
  } itar_poweron_func_type;

  typedef struct packed {
    logic [5:0]          func_sel;
    logic [2:0]          logic_sel;
    logic [15:0]         mask_a;
    logic [15:0]         mask_b;
    logic [15:0]         act_a;
    logic [15:0]         act_b;
    logic                primed;
    logic signed [15:0]  offset;
    logic [15:0]         filter_tc;
    logic [15:0]         dead_band;
    logic signed [15:0]  drift;
    itar_adj_state_type  adj;
    logic [15:0]         spd10;
    logic [15:0]         trq10;
    itar_mode_cfg_type   mode_cfg;
    logic                flt_drift;
    logic                flt_ov;
    logic                in_prev;
    logic                fly_pulse;
    logic signed [20:0]  corr;
    logic signed [20:0]  filt;
    logic signed [31:0]  spd_ref;
    logic signed [31:0]  trq_ref;
    logic [31:0]         prdata;
  } itar_state_type;
endpackage
`default_nettype wire

// [itar_core.sv]
// Fast input allocation, power-on masks and analog input one conditioning
// Summary of operation
// - Fast input logic selection applies only while a function is allocated; codes 0-4.
// - Fast input always acts as fly position change trigger.
// - Any other allocated function raises the misallocation fault.
// - The fly trigger is detected on edges, never on levels.
// - Mask A bits activate functions 33 up at power-up; writes wait for power-up.
// - Mask A bits 0-4 map to the five named functions; rest unused.
// - Mask B bits 0-15 activate functions 49-64 at power-up.
// - Signed millivolt offset is removed from the sample, effective at once.
// - Sample is low-pass filtered with a time constant in 0.01 ms steps.
// - The filter does not correct drift or dead zone.
// - Sample inside the dead band is forced to zero.
// - Auto adjust command 1 measures drift and stores it, within 500.0 mV.
// - Measured drift beyond 500.0 mV raises the drift fault.
// - Sample beyond 11.5 V raises the overvoltage fault.
// - Speed reference is sample over 10 V times speed setting.
// - Speed scaling used for feedforward, speed reference and speed limit sources.
// - Torque reference is sample over 10 V times gain 1.00 to 8.00.
// - Torque scaling used for torque reference and torque limit sources.
// - Logic codes: low, high, rising, falling, both edges.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "itar_defs.svh"
module itar_core (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire itar_pkg::itar_apb_req_type    apb_req,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  input  wire logic                          fast_input_b,
  input  wire logic                          motor_stopped,
  input  wire logic [15:0]                   retained_mask_a,
  input  wire logic [15:0]                   retained_mask_b,
  input  wire logic                          adc_valid,
  input  wire logic signed [15:0]            adc_sample_mv,
  output itar_pkg::itar_fault_type           fault,
  output logic                               fly_trigger,
  output itar_pkg::itar_poweron_func_type    poweron_a,
  output logic [15:0]                        poweron_b,
  output logic [15:0]                        stored_mask_a,
  output logic [15:0]                        stored_mask_b,
  output logic signed [20:0]                 conditioned_sample,
  output logic signed [31:0]                 speed_ref,
  output logic signed [31:0]                 torque_ref,
  output logic                               speed_ref_used,
  output logic                               torque_ref_used
);
  localparam itar_pkg::itar_state_type ST_RST = '{
    func_sel:  `ITAR_FUNC_NONE,
    logic_sel: `ITAR_LOGIC_LOW,
    filter_tc: `ITAR_FILTER_RST,
    dead_band: `ITAR_DEAD_RST,
    spd10:     `ITAR_SPD10_RST,
    trq10:     `ITAR_TRQ10_RST,
    adj:       itar_pkg::ITAR_ADJ_IDLE,
    mode_cfg:  '{mode: itar_pkg::ITAR_MODE_POSITION, default: 2'h0},
    default:   '0
  };

  itar_pkg::itar_state_type st;
  itar_pkg::itar_state_type next_st;

  function automatic logic signed [20:0] mul10(input logic signed [20:0] v);
    mul10 = (v <<< 3) + (v <<< 1);
  endfunction

  function automatic logic [20:0] mag(input logic signed [20:0] v);
    mag = v[20] ? 21'(-v) : 21'(v);
  endfunction

  function automatic logic [4:0] tc_shift(input logic [15:0] tc);
    tc_shift = 5'h00;
    for (int i = 1; i < 16; i++) begin
      if (tc[i]) begin
        tc_shift = 5'(i);
      end
    end
  endfunction

  function automatic logic ai_one_or_two(input logic [1:0] src);
    ai_one_or_two = (src == 2'h1) || (src == 2'h2);
  endfunction

  logic                acc;
  logic                wr_acc;
  logic                rd_setup;
  logic                mapped;
  logic                cfg_locked;
  logic                allocated;
  logic                misalloc;
  logic                edge_hit;
  logic                in_dead;
  logic [2:0]          eff_logic;
  logic signed [20:0]  sample_x10;
  logic signed [20:0]  meas;
  logic signed [20:0]  corr_raw;
  logic signed [20:0]  corr_dz;
  logic signed [20:0]  filt_step;
  logic signed [21:0]  filt_diff;
  logic signed [37:0]  spd_prod;
  logic signed [37:0]  trq_prod;

  assign acc        = apb_req.psel & apb_req.penable;
  assign wr_acc     = acc & apb_req.pwrite;
  assign rd_setup   = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  assign mapped     = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr <= `ITAR_ADDR_TRQ_REF);
  assign cfg_locked = (apb_req.paddr == `ITAR_ADDR_FAST_CFG) && ~motor_stopped;
  assign pready     = 1'b1;
  assign pslverr    = acc & (~mapped | (apb_req.pwrite & cfg_locked));
  assign prdata     = st.prdata;

  // Fast input trigger
  assign allocated = st.func_sel != `ITAR_FUNC_NONE;
  assign misalloc  = allocated && (st.func_sel != `ITAR_FUNC_FLY);
  assign eff_logic = allocated ? st.logic_sel : `ITAR_LOGIC_LOW;

  always_comb begin
    case (eff_logic)
      `ITAR_LOGIC_LOW:  edge_hit = st.in_prev & ~fast_input_b;
      `ITAR_LOGIC_HIGH: edge_hit = ~st.in_prev & fast_input_b;
      `ITAR_LOGIC_RISE: edge_hit = ~st.in_prev & fast_input_b;
      `ITAR_LOGIC_FALL: edge_hit = st.in_prev & ~fast_input_b;
      `ITAR_LOGIC_BOTH: edge_hit = st.in_prev ^ fast_input_b;
      default:          edge_hit = 1'b0;
    endcase
  end

  // Analog chain, in 0.1 mV steps
  assign sample_x10 = mul10(21'(adc_sample_mv));
  assign meas       = sample_x10 - mul10(21'(st.offset));
  assign corr_raw   = meas - 21'(st.drift);
  assign in_dead    = mag(corr_raw) <= {5'h00, st.dead_band};
  assign corr_dz    = in_dead ? 21'sh00000 : corr_raw;
  assign filt_diff  = 22'(corr_dz) - 22'(st.filt);
  assign filt_step  = 21'(filt_diff >>> tc_shift(st.filter_tc));
  assign spd_prod   = 38'(st.filt) * $signed({22'h00000, st.spd10});
  assign trq_prod   = 38'(st.filt) * $signed({22'h00000, st.trq10});

  always_comb begin
    next_st = st;
    next_st.in_prev = fast_input_b;
    next_st.fly_pulse = edge_hit;
    if (!st.primed) begin
      next_st.primed = 1'b1;
      next_st.mask_a = retained_mask_a;
      next_st.mask_b = retained_mask_b;
      next_st.act_a  = retained_mask_a;
      next_st.act_b  = retained_mask_b;
    end
    if (adc_valid) begin
      next_st.corr = corr_dz;
      if (st.filter_tc == 16'h0000) begin
        next_st.filt = corr_dz;
      end else begin
        next_st.filt = st.filt + filt_step;
      end
    end
    next_st.spd_ref = 32'(spd_prod / $signed(`ITAR_TEN_VOLTS));
    next_st.trq_ref = 32'(trq_prod / $signed(`ITAR_TEN_VOLTS));
    if (wr_acc) begin
      case (apb_req.paddr)
        `ITAR_ADDR_FAST_CFG: begin
          if (motor_stopped) begin
            next_st.func_sel  = apb_req.pwdata[5:0];
            next_st.logic_sel = (apb_req.pwdata[10:8] > `ITAR_LOGIC_BOTH) ?
                                st.logic_sel : apb_req.pwdata[10:8];
          end
        end
        `ITAR_ADDR_MASK_A: next_st.mask_a = apb_req.pwdata[15:0];
        `ITAR_ADDR_MASK_B: next_st.mask_b = apb_req.pwdata[15:0];
        `ITAR_ADDR_OFFSET: next_st.offset = apb_req.pwdata[15:0];
        `ITAR_ADDR_FILTER: next_st.filter_tc = apb_req.pwdata[15:0];
        `ITAR_ADDR_DEAD:   next_st.dead_band = apb_req.pwdata[15:0];
        `ITAR_ADDR_DRIFT:  next_st.drift = apb_req.pwdata[15:0];
        `ITAR_ADDR_ADJUST: begin
          if (apb_req.pwdata == `ITAR_ADJ_START) begin
            next_st.adj = itar_pkg::ITAR_ADJ_MEASURE;
          end
        end
        `ITAR_ADDR_SPD10: next_st.spd10 = apb_req.pwdata[15:0];
        `ITAR_ADDR_TRQ10: begin
          if (apb_req.pwdata[15:0] < `ITAR_TRQ10_MIN) begin
            next_st.trq10 = `ITAR_TRQ10_MIN;
          end else if (apb_req.pwdata[15:0] > `ITAR_TRQ10_MAX) begin
            next_st.trq10 = `ITAR_TRQ10_MAX;
          end else begin
            next_st.trq10 = apb_req.pwdata[15:0];
          end
        end
        `ITAR_ADDR_MODE: next_st.mode_cfg = apb_req.pwdata[11:0];
        `ITAR_ADDR_STATUS: begin
          if (apb_req.pwdata[`ITAR_ST_DRIFT]) begin
            next_st.flt_drift = 1'b0;
          end
          if (apb_req.pwdata[`ITAR_ST_OV]) begin
            next_st.flt_ov = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Hardware sets after the clear, so an event is never lost
    if (adc_valid && (mag(sample_x10) > `ITAR_OV_LIMIT)) begin
      next_st.flt_ov = 1'b1;
    end
    case (st.adj)
      itar_pkg::ITAR_ADJ_IDLE: begin
      end
      itar_pkg::ITAR_ADJ_MEASURE: begin
        if (adc_valid) begin
          next_st.adj = itar_pkg::ITAR_ADJ_IDLE;
          if (mag(meas) > `ITAR_DRIFT_LIMIT) begin
            next_st.flt_drift = 1'b1;
          end else begin
            next_st.drift = meas[15:0];
          end
        end
      end
      default: next_st.adj = itar_pkg::ITAR_ADJ_IDLE;
    endcase
    if (rd_setup) begin
      case (apb_req.paddr)
        `ITAR_ADDR_FAST_CFG: next_st.prdata = {21'h0, st.logic_sel, 2'h0, st.func_sel};
        `ITAR_ADDR_MASK_A:   next_st.prdata = {16'h0000, st.mask_a};
        `ITAR_ADDR_MASK_B:   next_st.prdata = {16'h0000, st.mask_b};
        `ITAR_ADDR_OFFSET:   next_st.prdata = 32'(st.offset);
        `ITAR_ADDR_FILTER:   next_st.prdata = {16'h0000, st.filter_tc};
        `ITAR_ADDR_DEAD:     next_st.prdata = {16'h0000, st.dead_band};
        `ITAR_ADDR_DRIFT:    next_st.prdata = 32'(st.drift);
        `ITAR_ADDR_ADJUST:   next_st.prdata = {31'h0, st.adj == itar_pkg::ITAR_ADJ_MEASURE};
        `ITAR_ADDR_SPD10:    next_st.prdata = {16'h0000, st.spd10};
        `ITAR_ADDR_TRQ10:    next_st.prdata = {16'h0000, st.trq10};
        `ITAR_ADDR_MODE:     next_st.prdata = {20'h00000, st.mode_cfg};
        `ITAR_ADDR_STATUS:   next_st.prdata = {27'h0, motor_stopped,
                                               st.adj == itar_pkg::ITAR_ADJ_MEASURE,
                                               st.flt_ov, st.flt_drift, misalloc};
        `ITAR_ADDR_SAMPLE:   next_st.prdata = 32'(st.filt);
        `ITAR_ADDR_SPD_REF:  next_st.prdata = st.spd_ref;
        `ITAR_ADDR_TRQ_REF:  next_st.prdata = st.trq_ref;
        default:             next_st.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign fault              = '{misalloc: misalloc, drift: st.flt_drift, overvolt: st.flt_ov};
  assign fly_trigger        = st.fly_pulse;
  assign poweron_a          = st.act_a[4:0];
  assign poweron_b          = st.act_b;
  assign stored_mask_a      = st.mask_a;
  assign stored_mask_b      = st.mask_b;
  assign conditioned_sample = st.filt;
  assign speed_ref          = st.spd_ref;
  assign torque_ref         = st.trq_ref;
  assign speed_ref_used     =
    ((st.mode_cfg.mode == itar_pkg::ITAR_MODE_POSITION) && st.mode_cfg.ff_src[1]) ||
    ((st.mode_cfg.mode == itar_pkg::ITAR_MODE_SPEED) && ai_one_or_two(st.mode_cfg.spd_src)) ||
    ((st.mode_cfg.mode == itar_pkg::ITAR_MODE_TORQUE) && ai_one_or_two(st.mode_cfg.slim_src));
  assign torque_ref_used    =
    ((st.mode_cfg.mode == itar_pkg::ITAR_MODE_SPEED) && ai_one_or_two(st.mode_cfg.trq_src)) ||
    ((st.mode_cfg.mode == itar_pkg::ITAR_MODE_TORQUE) && ai_one_or_two(st.mode_cfg.tlim_src));

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_fly_code_clean: assert property (
    wr_acc && motor_stopped && apb_req.paddr == `ITAR_ADDR_FAST_CFG &&
    apb_req.pwdata[5:0] == `ITAR_FUNC_FLY |=> !fault.misalloc)
    else $error("fly code still flags misallocation");
  chk_fly_rise_edge: assert property (
    allocated && st.logic_sel == `ITAR_LOGIC_RISE && $rose(fast_input_b) |=> fly_trigger)
    else $error("rising edge gave no fly trigger");
  chk_fly_unalloc: assert property (
    !allocated && $fell(fast_input_b) |=> fly_trigger)
    else $error("unallocated input gave no fly trigger");
  chk_fly_no_level: assert property (
    $stable(fast_input_b) |=> !fly_trigger)
    else $error("fly trigger without an edge");
  chk_mask_b_snap: assert property (
    $rose(st.primed) |-> poweron_b == $past(retained_mask_b))
    else $error("mask b not captured at power-up");
  chk_halt_map: assert property (
    $rose(st.primed) |-> poweron_a.emergency_halt == $past(retained_mask_a[1]))
    else $error("halt bit not mapped from mask a");
  chk_mask_a_hold: assert property (
    st.primed ##1 st.primed |-> $stable(st.act_a))
    else $error("active mask changed after power-up");
  chk_overvolt_set: assert property (
    adc_valid && mag(sample_x10) > `ITAR_OV_LIMIT |=> fault.overvolt)
    else $error("overvoltage fault missing");
  chk_dead_zero: assert property (
    adc_valid && in_dead |=> st.corr == 21'sh00000)
    else $error("dead band sample not zero");
  chk_drift_excess: assert property (
    st.adj == itar_pkg::ITAR_ADJ_MEASURE && adc_valid && mag(meas) > `ITAR_DRIFT_LIMIT
    |=> fault.drift && st.adj == itar_pkg::ITAR_ADJ_IDLE)
    else $error("drift fault missing");
  chk_drift_store: assert property (
    st.adj == itar_pkg::ITAR_ADJ_MEASURE && adc_valid && mag(meas) <= `ITAR_DRIFT_LIMIT
    |=> st.drift == $past(meas[15:0]))
    else $error("measured drift not stored");
  chk_cfg_locked: assert property (
    wr_acc && cfg_locked |=> $stable(st.func_sel) && $stable(st.logic_sel))
    else $error("fast input config changed while running");
endmodule
`default_nettype wire

// [itar_top_note_placeholder.sv]
// Empty compilation unit kept for folder completeness
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [itar_host_model.sv]
// Host side model driving the fast input and analog input one
`timescale 1ns/1ps
`default_nettype none
module itar_host_model #(
  // Shortened minimum hold so that runs stay brief
  parameter int HOLD_CYCLES = 40
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               req_level,
  input  wire logic               req_sample,
  input  wire logic signed [15:0] req_mv,
  output logic                    fast_input_b,
  output logic                    adc_valid,
  output logic signed [15:0]      adc_sample_mv
);
  int hold_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_input_b  <= 1'b0;
      hold_cnt      <= 0;
      adc_valid     <= 1'b0;
      adc_sample_mv <= 16'sh0000;
    end else begin
      // Level moves only after the minimum hold
      if (req_level != fast_input_b && hold_cnt >= HOLD_CYCLES) begin
        fast_input_b <= req_level;
        hold_cnt     <= 0;
      end else if (hold_cnt < HOLD_CYCLES) begin
        hold_cnt <= hold_cnt + 1;
      end
      // Stale sample inverted outside the valid pulse
      adc_valid     <= req_sample;
      adc_sample_mv <= req_sample ? req_mv : ~adc_sample_mv;
    end
  end
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking testbench of the input terminal and analog block
`timescale 1ns/1ps
`default_nettype none
`include "itar_defs.svh"
module testbench;
  logic                            pclk, presetn, motor_stopped, req_level, req_sample;
  logic signed [15:0]              req_mv, adc_sample_mv;
  logic [15:0]                     retained_mask_a, retained_mask_b;
  logic [15:0]                     poweron_b, stored_mask_a, stored_mask_b;
  itar_pkg::itar_apb_req_type      apb_req;
  itar_pkg::itar_fault_type        fault;
  itar_pkg::itar_poweron_func_type poweron_a;
  logic                            pready, pslverr, fast_input_b, adc_valid, fly_trigger;
  logic                            speed_ref_used, torque_ref_used, err;
  logic [31:0]                     prdata, rd;
  logic signed [20:0]              conditioned_sample;
  logic signed [31:0]              speed_ref, torque_ref;
  int                              n_fail, checks, fly_cnt, base;
  logic [11:0]                     md_tab [5] = '{12'h008, 12'h004, 12'h091, 12'h602, 12'h002};
  logic [1:0]                      use_tab [5] = '{2'b10, 2'b00, 2'b11, 2'b11, 2'b00};

  itar_core dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .fast_input_b(fast_input_b),
    .motor_stopped(motor_stopped), .retained_mask_a(retained_mask_a),
    .retained_mask_b(retained_mask_b), .adc_valid(adc_valid), .adc_sample_mv(adc_sample_mv),
    .fault(fault), .fly_trigger(fly_trigger), .poweron_a(poweron_a), .poweron_b(poweron_b),
    .stored_mask_a(stored_mask_a), .stored_mask_b(stored_mask_b),
    .conditioned_sample(conditioned_sample), .speed_ref(speed_ref), .torque_ref(torque_ref),
    .speed_ref_used(speed_ref_used), .torque_ref_used(torque_ref_used));

  itar_host_model #(.HOLD_CYCLES(40)) host (.pclk(pclk), .presetn(presetn),
    .req_level(req_level), .req_sample(req_sample), .req_mv(req_mv),
    .fast_input_b(fast_input_b), .adc_valid(adc_valid), .adc_sample_mv(adc_sample_mv));

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
    apb(a, 1'b1, d);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  task automatic sample(input logic signed [15:0] mv);
    @(posedge pclk);
    req_mv <= mv;
    req_sample <= 1'b1;
    @(posedge pclk);
    req_sample <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  always @(posedge pclk)
    if (fly_trigger === 1'b1) fly_cnt <= fly_cnt + 1;

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    #(20000 * 10);
    n_fail++;
    complete_run();
  end

  initial begin
    logic [2:0] lg;
    logic       e_r, e_f;
    presetn = 1'b0; apb_req = '0; motor_stopped = 1'b1; req_level = 1'b0;
    req_sample = 1'b0; req_mv = 16'sh0000; retained_mask_a = 16'h0015;
    retained_mask_b = 16'ha5a5; n_fail = 0; checks = 0; fly_cnt = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({27'h0, poweron_a}, 32'h00000015);
    chk({16'h0, poweron_b}, 32'h0000a5a5);
    rdchk(`ITAR_ADDR_FILTER, {16'h0, `ITAR_FILTER_RST});
    rdchk(`ITAR_ADDR_DEAD, {16'h0, `ITAR_DEAD_RST});
    rdchk(`ITAR_ADDR_SPD10, {16'h0, `ITAR_SPD10_RST});
    rdchk(`ITAR_ADDR_TRQ10, {16'h0, `ITAR_TRQ10_RST});
    rdchk(`ITAR_ADDR_FAST_CFG, 32'h0);
    apb(8'h3c, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(`ITAR_ADDR_MASK_A, 32'h0000ffff, 1'b0);
    rdchk(`ITAR_ADDR_MASK_A, 32'h0000ffff);
    chk({27'h0, poweron_a}, 32'h00000015);
    chk({16'h0, stored_mask_a}, 32'h0000ffff);
    chk({16'h0, stored_mask_b}, 32'h0000a5a5);
    motor_stopped <= 1'b0;
    wr(`ITAR_ADDR_FAST_CFG, 32'h20, 1'b1);
    rdchk(`ITAR_ADDR_FAST_CFG, 32'h0);
    motor_stopped <= 1'b1;
    wr(`ITAR_ADDR_FAST_CFG, 32'h05, 1'b0);
    @(posedge pclk);
    chk({31'h0, fault.misalloc}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      lg = (i == 5) ? 3'h1 : 3'(i);
      e_r = (i == 1 || i == 2 || i == 4);
      e_f = (i == 0 || i == 3 || i == 4 || i == 5);
      wr(`ITAR_ADDR_FAST_CFG, {21'h0, lg, 2'b00, (i == 5) ? 6'h00 : 6'h20}, 1'b0);
      @(posedge pclk);
      chk({31'h0, fault.misalloc}, 32'h0);
      base = fly_cnt;
      req_level <= 1'b1;
      repeat (60) @(posedge pclk);
      chk(32'(fly_cnt - base), {31'h0, e_r});
      req_level <= 1'b0;
      repeat (60) @(posedge pclk);
      chk(32'(fly_cnt - base), 32'(e_r) + 32'(e_f));
    end
    wr(`ITAR_ADDR_FAST_CFG, 32'h00000720, 1'b0);
    rdchk(`ITAR_ADDR_FAST_CFG, 32'h00000120);
    wr(`ITAR_ADDR_FILTER, 32'h0, 1'b0);
    sample(16'sd5);
    chk(32'(conditioned_sample), 32'h0);
    sample(16'sd1000);
    chk(32'(conditioned_sample), 32'd10000);
    wr(`ITAR_ADDR_OFFSET, 32'd200, 1'b0);
    sample(16'sd1000);
    chk(32'(conditioned_sample), 32'd8000);
    chk(speed_ref, 32'd240);
    chk(torque_ref, 32'd8);
    sample(16'sd11500);
    chk({31'h0, fault.overvolt}, 32'h0);
    sample(16'sd11501);
    chk({31'h0, fault.overvolt}, 32'h1);
    wr(`ITAR_ADDR_OFFSET, 32'h0, 1'b0);
    sample(16'sd5);
    wr(`ITAR_ADDR_FILTER, 32'd16, 1'b0);
    sample(16'sd1000);
    chk(32'(conditioned_sample), 32'd625);
    rdchk(`ITAR_ADDR_SAMPLE, 32'd625);
    for (int i = 0; i < 5; i++) begin
      wr(`ITAR_ADDR_MODE, {20'h0, md_tab[i]}, 1'b0);
      @(posedge pclk);
      chk({31'h0, speed_ref_used}, {31'h0, use_tab[i][1]});
      chk({31'h0, torque_ref_used}, {31'h0, use_tab[i][0]});
    end
    wr(`ITAR_ADDR_ADJUST, `ITAR_ADJ_START, 1'b0);
    rdchk(`ITAR_ADDR_ADJUST, 32'h1);
    sample(16'sd500);
    rdchk(`ITAR_ADDR_DRIFT, 32'h00001388);
    chk({31'h0, fault.drift}, 32'h0);
    wr(`ITAR_ADDR_ADJUST, `ITAR_ADJ_START, 1'b0);
    sample(16'sd600);
    chk({31'h0, fault.drift}, 32'h1);
    rdchk(`ITAR_ADDR_STATUS, 32'h00000016);
    wr(`ITAR_ADDR_STATUS, 32'h00000006, 1'b0);
    rdchk(`ITAR_ADDR_STATUS, 32'h00000010);
    complete_run();
  end
endmodule
`default_nettype wire
